//--- rtl/tiecs_map.vh
// Purpose: constants for the 16-bit interval / event / clear-start timer
// Assumes: 32-bit APB, byte address is four times the register index
// Notes: definitions only
`ifndef TIECS_MAP_VH
`define TIECS_MAP_VH

// register indices (byte address = index * 4)
`define TIECS_IDX_DIR 16'hff23
`define TIECS_IDX_SW 16'hff4f
`define TIECS_IDX_TMC 16'hffba
`define TIECS_IDX_PRM 16'hffbb
`define TIECS_IDX_CRC 16'hffbc
`define TIECS_IDX_CNT 16'hff10
`define TIECS_IDX_CRA 16'hff12
`define TIECS_IDX_CRB 16'hff14
`define TIECS_IDX_P3L 16'hff03

// reset values
`define TIECS_RST_DIR 8'hff
`define TIECS_RST_SW 8'h00
`define TIECS_RST_TMC 8'h00
`define TIECS_RST_PRM 8'h00
`define TIECS_RST_CRC 8'h00
`define TIECS_RST_P3L 8'h00
`define TIECS_RST_CNT 16'h0000
`define TIECS_RST_CR 16'h0000

// input switch fields
`define TIECS_SW_IRQSRC 0
`define TIECS_SW_TSRC 1
`define TIECS_SW_RXEN 3
// mode control fields
`define TIECS_TMC_OVF 0
`define TIECS_TMC_MLO 2
`define TIECS_TMC_MHI 3
// prescaler fields
`define TIECS_PRM_C0 0
`define TIECS_PRM_C1 1
`define TIECS_PRM_ESLO 4
`define TIECS_PRM_ESHI 5
`define TIECS_PRM_C2 7
// capture/compare control field
`define TIECS_CRC_CAPB 2
// port 3 direction: upper nibble is fixed at one
`define TIECS_DIR_FIXED 8'hf0

// operating modes
`define TIECS_MODE_STOP 2'h0
`define TIECS_MODE_FREE 2'h1
`define TIECS_MODE_PIN 2'h2
`define TIECS_MODE_CMPA 2'h3

// count clock selections
`define TIECS_CK_DIV1 3'h0
`define TIECS_CK_DIV2 3'h1
`define TIECS_CK_DIV4 3'h2
`define TIECS_CK_DIV16 3'h3
`define TIECS_CK_DIV256 3'h4
`define TIECS_CK_SUB 3'h5
`define TIECS_CK_PIN 3'h6
`define TIECS_CK_EXT 3'h7

// edge selections
`define TIECS_ES_FALL 2'h0
`define TIECS_ES_RISE 2'h1
`define TIECS_ES_BOTH 2'h3

`define TIECS_CNT_MAX 16'hffff

`endif

//--- rtl/tiecs_edge.v
// Purpose: glitch filter and valid edge detector for the timer input
// Assumes: pin is synchronous to pclk
// Notes: a level counts only after two equal successive samples
`timescale 1ns/1ns
`include "tiecs_map.vh"

module tiecs_edge (
  // clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // input and selection
  input wire pin,
  input wire [1:0] edge_sel,
  // result
  output reg valid_edge
);

  reg samp_a_r;
  reg samp_b_r;
  reg level_r;
  wire rise;
  wire fall;

  // filtered level moves only when two samples agree
  assign rise = (samp_a_r == samp_b_r) && samp_b_r && !level_r;
  assign fall = (samp_a_r == samp_b_r) && !samp_b_r && level_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_a_r <= 1'b0;
      samp_b_r <= 1'b0;
      level_r <= 1'b0;
      valid_edge <= 1'b0;
    end else if (ce) begin
      samp_a_r <= pin;
      samp_b_r <= samp_a_r;
      if (rise || fall) begin
        level_r <= samp_b_r;
      end
      case (edge_sel)
        `TIECS_ES_FALL: valid_edge <= fall;
        `TIECS_ES_RISE: valid_edge <= rise;
        `TIECS_ES_BOTH: valid_edge <= rise | fall;
        default: valid_edge <= 1'b0; // prohibited code: no edges
      endcase
    end
  end

endmodule

//--- rtl/tiecs_top.v
// Purpose: 16-bit timer with interval, event count and pin clear-start
// Assumes: APB3 slave, pclk 100 MHz, pins synchronous to pclk
// Notes: no access wait states; ce low freezes everything incl. APB
`timescale 1ns/1ns
`include "tiecs_map.vh"

// Behaviour
// - timer input from port pin when source bit 0, serial pin when 1
// - interrupt 0 input from its own pin when bit 0, serial pin when 1
// - input switch register resets to all zeros
// - direction bit 0 drives the pin, 1 turns the buffer off
// - port 3 direction register resets to all ones
// - mode 11 counts on the selected count clock
// - mode 11 match with register A clears counter and pulses match A
// - match A interval is compare value plus one count clocks
// - match B pulse still raised; software masks it if unused
// - pin edge clock with mode 11 counts events, match A pulses
// - first event match after value plus two edges, later plus one
// - pin edge accepted after two equal successive samples
// - mode 10 counts, pin edge clears and restarts, else wraps
// - mode 10 counts at once without waiting for an edge
// - mode 10: A compare only, B compare or capture
// - mode 10 compare matches pulse match A and match B
// - counter read returns live count without disturbing it
// - mode 00 stops and clears; 01 free, 10 pin clear, 11 compare
// - overflow flag set on wrap, cleared by software or stop
// - edge select 00 fall, 01 rise, 11 both, 10 prohibited
// - capture bit 0 compare B, 1 capture count on pin edge in modes 01 and 10
module tiecs_top (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // port 3 pins 0..3
  input wire [3:0] port3_in,
  output reg [3:0] port3_out,
  output reg [3:0] port3_oe_n,
  // other input pins and count sources
  input wire serial_receive_pin,
  input wire ext_irq0_pin,
  input wire subclk_tick,
  input wire tm52_tick,
  // results
  output reg match_a_irq,
  output reg match_b_irq,
  output reg irq0_input,
  output reg rx_pin_input_enable
);

  // register select codes
  localparam [3:0] SEL_NONE = 4'h0;
  localparam [3:0] SEL_DIR = 4'h1;
  localparam [3:0] SEL_SW = 4'h2;
  localparam [3:0] SEL_TMC = 4'h3;
  localparam [3:0] SEL_PRM = 4'h4;
  localparam [3:0] SEL_CRC = 4'h5;
  localparam [3:0] SEL_CNT = 4'h6;
  localparam [3:0] SEL_CRA = 4'h7;
  localparam [3:0] SEL_CRB = 4'h8;
  localparam [3:0] SEL_P3L = 4'h9;

  // software registers
  reg [7:0] port3_direction_r;
  reg [7:0] input_source_switch_r;
  reg [3:2] mode_r;
  reg overflow_flag_r;
  reg [7:0] prescaler_mode_ctrl_r;
  reg reg_b_capture_sel_r;
  reg [15:0] compare_reg_a_r;
  reg [15:0] capcomp_reg_b_r;
  reg [3:0] port3_latch_r;
  // timer state
  reg [15:0] count_value_r;
  reg [7:0] div_r;
  reg first_r;
  reg [31:0] rdata_nxt;

  wire [3:0] sel;
  wire wr_en;
  wire timer_src;
  wire pin_edge;
  wire running;
  wire [2:0] clk_sel;
  wire src_tick;
  wire evt_mode;
  wire tick;
  wire hit_a;
  wire hit_b;
  wire wrap;
  wire capture;

  // address decode, shared by read and write paths
  function [3:0] decode;
    input [17:0] addr;
    begin
      case (addr)
        {`TIECS_IDX_DIR, 2'b00}: decode = SEL_DIR;
        {`TIECS_IDX_SW, 2'b00}: decode = SEL_SW;
        {`TIECS_IDX_TMC, 2'b00}: decode = SEL_TMC;
        {`TIECS_IDX_PRM, 2'b00}: decode = SEL_PRM;
        {`TIECS_IDX_CRC, 2'b00}: decode = SEL_CRC;
        {`TIECS_IDX_CNT, 2'b00}: decode = SEL_CNT;
        {`TIECS_IDX_CRA, 2'b00}: decode = SEL_CRA;
        {`TIECS_IDX_CRB, 2'b00}: decode = SEL_CRB;
        {`TIECS_IDX_P3L, 2'b00}: decode = SEL_P3L;
        default: decode = SEL_NONE;
      endcase
    end
  endfunction

  // count clock select from prescaler taps and outside ticks
  function sel_tick;
    input [2:0] code;
    input [7:0] div;
    input pin_ev;
    input sub_ev;
    input ext_ev;
    begin
      case (code)
        `TIECS_CK_DIV1: sel_tick = 1'b1;
        `TIECS_CK_DIV2: sel_tick = div[0];
        `TIECS_CK_DIV4: sel_tick = &div[1:0];
        `TIECS_CK_DIV16: sel_tick = &div[3:0];
        `TIECS_CK_DIV256: sel_tick = &div[7:0];
        `TIECS_CK_SUB: sel_tick = sub_ev;
        `TIECS_CK_PIN: sel_tick = pin_ev;
        `TIECS_CK_EXT: sel_tick = ext_ev;
        default: sel_tick = 1'b0;
      endcase
    end
  endfunction

  assign sel = decode(paddr);
  // a write lands only at the completing edge of the access phase
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  assign timer_src = input_source_switch_r[`TIECS_SW_TSRC] ?
                     serial_receive_pin : port3_in[3];

  tiecs_edge u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin(timer_src),
    .edge_sel({prescaler_mode_ctrl_r[`TIECS_PRM_ESHI],
               prescaler_mode_ctrl_r[`TIECS_PRM_ESLO]}),
    .valid_edge(pin_edge)
  );

  assign clk_sel = {prescaler_mode_ctrl_r[`TIECS_PRM_C2],
                    prescaler_mode_ctrl_r[`TIECS_PRM_C1],
                    prescaler_mode_ctrl_r[`TIECS_PRM_C0]};
  // any mode but 00 runs the count clock
  assign running = (mode_r != `TIECS_MODE_STOP);
  assign src_tick = sel_tick(clk_sel, div_r, pin_edge, subclk_tick,
                             tm52_tick);
  // pin edge as count clock with compare clear counts events
  assign evt_mode = (clk_sel == `TIECS_CK_PIN) &&
                    (mode_r == `TIECS_MODE_CMPA);
  // first event after start only arms the counter
  assign tick = running && src_tick && !(evt_mode && first_r);
  // equality with register A on a count clock
  assign hit_a = tick && (count_value_r == compare_reg_a_r);
  // compare B still fires when B is in compare use
  assign hit_b = tick && !reg_b_capture_sel_r &&
                 (count_value_r == capcomp_reg_b_r);
  // wrap from all ones, unless a pin edge clears instead
  assign wrap = tick && (count_value_r == `TIECS_CNT_MAX) &&
                !(mode_r == `TIECS_MODE_PIN && pin_edge);
  // capture into B on a valid edge, not in compare-clear mode
  assign capture = running && reg_b_capture_sel_r && pin_edge &&
                   (mode_r != `TIECS_MODE_CMPA);

  // prescaler divider: held at zero while stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 8'h00;
    end else if (ce) begin
      if (running) begin
        div_r <= div_r + 8'h01;
      end else begin
        div_r <= 8'h00;
      end
    end
  end

  // counter by mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r <= `TIECS_RST_CNT;
      first_r <= 1'b1;
    end else if (ce) begin
      if (src_tick) begin
        first_r <= !running;
      end else if (!running) begin
        first_r <= 1'b1;
      end
      case (mode_r)
        `TIECS_MODE_STOP: count_value_r <= 16'h0000;
        `TIECS_MODE_FREE: begin
          if (tick) begin
            count_value_r <= count_value_r + 16'h0001;
          end
        end
        `TIECS_MODE_PIN: begin
          // edge clears, else count and wrap
          // counts from entry, no edge needed
          // pin edge as clock just keeps clearing
          if (pin_edge) begin
            count_value_r <= 16'h0000;
          end else if (tick) begin
            count_value_r <= count_value_r + 16'h0001;
          end
        end
        `TIECS_MODE_CMPA: begin
          // 0..M gives M plus one clocks a period
          if (hit_a) begin
            count_value_r <= 16'h0000;
          end else if (tick) begin
            count_value_r <= count_value_r + 16'h0001;
          end
        end
        default: count_value_r <= 16'h0000;
      endcase
    end
  end

  // match pulses and interrupt 0 source, all from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
      irq0_input <= 1'b0;
      rx_pin_input_enable <= 1'b0;
    end else if (ce) begin
      // one cycle per detecting count clock
      // both compares fire in mode 10 too
      match_a_irq <= hit_a;
      match_b_irq <= hit_b;
      irq0_input <= input_source_switch_r[`TIECS_SW_IRQSRC] ?
                    serial_receive_pin : ext_irq0_pin;
      rx_pin_input_enable <= input_source_switch_r[`TIECS_SW_RXEN];
    end
  end

  // software registers; hardware set beats software clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port3_direction_r <= `TIECS_RST_DIR;
      input_source_switch_r <= `TIECS_RST_SW;
      mode_r <= `TIECS_MODE_STOP;
      overflow_flag_r <= 1'b0;
      prescaler_mode_ctrl_r <= `TIECS_RST_PRM;
      reg_b_capture_sel_r <= 1'b0;
      compare_reg_a_r <= `TIECS_RST_CR;
      capcomp_reg_b_r <= `TIECS_RST_CR;
      port3_latch_r <= 4'h0;
    end else if (ce) begin
      if (wr_en) begin
        case (sel)
          // upper bits stay fixed at input
          SEL_DIR: port3_direction_r <= pwdata[7:0] | `TIECS_DIR_FIXED;
          SEL_SW: input_source_switch_r <= pwdata[7:0] & 8'h0b;
          SEL_TMC: begin
            mode_r <= pwdata[`TIECS_TMC_MHI:`TIECS_TMC_MLO];
            overflow_flag_r <= pwdata[`TIECS_TMC_OVF];
          end
          SEL_PRM: prescaler_mode_ctrl_r <= pwdata[7:0] & 8'hb3;
          SEL_CRC: reg_b_capture_sel_r <= pwdata[`TIECS_CRC_CAPB];
          SEL_CRA: compare_reg_a_r <= pwdata[15:0];
          SEL_CRB: capcomp_reg_b_r <= pwdata[15:0];
          SEL_P3L: port3_latch_r <= pwdata[3:0];
          default: port3_latch_r <= port3_latch_r;
        endcase
      end
      // stop clears, a wrap sets over any clear
      if (!running && !(wr_en && sel == SEL_TMC)) begin
        overflow_flag_r <= 1'b0;
      end
      if (wrap) begin
        overflow_flag_r <= 1'b1;
      end
      // hardware capture wins over a bus write
      if (capture) begin
        capcomp_reg_b_r <= count_value_r;
      end
    end
  end

  // pin drivers: direction 1 turns the output buffer off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port3_out <= 4'h0;
      port3_oe_n <= 4'hf;
    end else if (ce) begin
      port3_out <= port3_latch_r;
      port3_oe_n <= port3_direction_r[3:0];
    end
  end

  // read data mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (sel)
      SEL_DIR: rdata_nxt[7:0] = port3_direction_r;
      SEL_SW: rdata_nxt[7:0] = input_source_switch_r;
      SEL_TMC: rdata_nxt[7:0] = {4'h0, mode_r, 1'b0, overflow_flag_r};
      SEL_PRM: rdata_nxt[7:0] = prescaler_mode_ctrl_r;
      SEL_CRC: rdata_nxt[7:0] = {5'h00, reg_b_capture_sel_r, 2'h0};
      SEL_CNT: rdata_nxt[15:0] = count_value_r;
      SEL_CRA: rdata_nxt[15:0] = compare_reg_a_r;
      SEL_CRB: rdata_nxt[15:0] = capcomp_reg_b_r;
      SEL_P3L: rdata_nxt[3:0] = port3_latch_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // apb handshake: data is latched in the setup cycle, one wait-free
  // access cycle follows; costs a flop stage but keeps outputs clean
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) begin
        pready <= 1'b1;
        pslverr <= (sel == SEL_NONE);
        prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

//--- tb/tiecs_evsrc.sv
// Purpose: event source driving the timer pin
// Assumes: one request at a time, go is a one-cycle pulse
// Notes: half of 1 gives a glitch too short for the filter
`timescale 1ns/1ns
module tiecs_evsrc (
  // clock
  input wire pclk,
  // request
  input wire go,
  input wire [7:0] n_edges,
  input wire [3:0] half,
  // pin and status
  output reg pin,
  output reg busy
);
  reg [7:0] left_r = 8'h00;
  reg [3:0] cnt_r = 4'h0;
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  always @(posedge pclk) begin
    if (go) begin
      left_r <= n_edges;
      cnt_r <= half;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_r > 4'h1)
        cnt_r <= cnt_r - 4'h1;
      else if (left_r == 8'h00)
        busy <= 1'b0;
      else begin
        pin <= ~pin;
        left_r <= left_r - 8'h01;
        cnt_r <= half;
      end
    end
  end
endmodule

//--- tb/tiecs_chk_assertions.sv
// Purpose: port checks for tiecs_top
// Assumes: ce held high
// Notes: switch and direction mirrored from apb writes
`timescale 1ns/1ns
`include "tiecs_map.vh"
module tiecs_chk (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins and results
  input wire [3:0] port3_oe_n,
  input wire serial_receive_pin,
  input wire ext_irq0_pin,
  input wire match_a_irq,
  input wire match_b_irq,
  input wire irq0_input
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  reg [7:0] sw_r;
  reg [7:0] dir_r;
  wire wr_w = psel && penable && pready && pwrite;
  wire irq0_exp_w = sw_r[0] ? serial_receive_pin : ext_irq0_pin;
  wire [3:0] dir_lo_w = dir_r[3:0];
  // mirrors land on the same edge as the design's write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_r <= 8'h00;
      dir_r <= 8'hff;
    end else begin
      if (wr_w && paddr == {`TIECS_IDX_SW, 2'b00})
        sw_r <= pwdata[7:0];
      if (wr_w && paddr == {`TIECS_IDX_DIR, 2'b00})
        dir_r <= pwdata[7:0];
    end
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  irq0_route_a: assert property ($past(presetn) |->
    irq0_input == $past(irq0_exp_w)) else $error("irq0 source wrong");
  dir_oe_a: assert property ($past(presetn) |->
    port3_oe_n == $past(dir_lo_w)) else $error("enable not direction");
  match_a_pulse_a: assert property (match_a_irq |=> !match_a_irq)
    else $error("match a longer than one cycle");
  match_b_pulse_a: assert property (match_b_irq |=> !match_b_irq)
    else $error("match b longer than one cycle");
  cover property (match_a_irq);
  cover property (match_b_irq);
  cover property (pslverr);
endmodule
bind tiecs_top tiecs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port3_oe_n,
  .serial_receive_pin, .ext_irq0_pin, .match_a_irq, .match_b_irq,
  .irq0_input);

//--- tb/tb.sv
// Purpose: self-checking bench for tiecs_top
// Assumes: ce held high, apb answers with no wait state
// Notes: timer pin edges come from the event source model
`timescale 1ns/1ns
`include "tiecs_map.vh"
`define CHK(nm, e, g) begin \
  samples_checked = samples_checked + 1; \
  if ((g) !== (e)) begin \
    error_cnt = error_cnt + 1; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [17:0] paddr = 18'h0;
  reg [31:0] pwdata = 32'h0;
  reg [2:0] p3_r = 3'h0;
  reg rx_r = 1'b0;
  reg ext_r = 1'b0;
  reg sub_r = 1'b0;
  reg t52_r = 1'b0;
  reg use_rx = 1'b0;
  reg go = 1'b0;
  reg [7:0] n_edges = 8'h0;
  reg [3:0] half = 4'h1;
  reg [31:0] rdv;
  reg errv;
  reg [7:0] r8;
  wire [31:0] prdata;
  wire pready, pslverr, match_a_irq, match_b_irq, irq0_input;
  wire [3:0] port3_oe_n;
  wire [3:0] p3o;
  wire rx_en_w;
  wire ev_pin, ev_busy;
  integer error_cnt = 0;
  integer samples_checked = 0;
  integer na = 0;
  integer nb = 0;
  integer cyc = 0;
  integer m, g, s, c1;
  tiecs_top u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port3_in({use_rx ? 1'b0 : ev_pin, p3_r}), .port3_out(p3o),
    .port3_oe_n(port3_oe_n),
    .serial_receive_pin(use_rx ? ev_pin : rx_r), .ext_irq0_pin(ext_r),
    .subclk_tick(sub_r), .tm52_tick(t52_r), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .irq0_input(irq0_input),
    .rx_pin_input_enable(rx_en_w));
  tiecs_evsrc u_src (.pclk(pclk), .go(go), .n_edges(n_edges),
    .half(half), .pin(ev_pin), .busy(ev_busy));
  initial begin
    forever #5 pclk = ~pclk;
  end
  // idle pins and unused ticks wander at random
  always @(posedge pclk) begin
    p3_r <= $urandom;
    sub_r <= ($urandom % 8) == 0;
    t52_r <= ($urandom % 8) == 0;
    if (match_a_irq === 1'b1)
      na = na + 1;
    if (match_b_irq === 1'b1)
      nb = nb + 1;
  end
  // hang guard well above the expected run
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task apb(input w, input [15:0] i, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
        error_cnt = error_cnt + 1;
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [15:0] i, input [31:0] d);
    apb(1'b1, i, d);
  endtask
  task rd(input [15:0] i);
    apb(1'b0, i, 32'h0);
  endtask
  // edges from the model, then time for filter and match
  task send(input [7:0] n, input [3:0] h);
    integer k;
    begin
      @(posedge pclk);
      go <= 1'b1;
      n_edges <= n;
      half <= h;
      @(posedge pclk);
      go <= 1'b0;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (ev_busy !== 1'b0 && k < 500);
      repeat (6) @(posedge pclk);
    end
  endtask
  // cycles between two match a pulses
  task gap;
    begin
      g = 0;
      while (match_a_irq !== 1'b1 && g < 2000) begin
        @(posedge pclk);
        g = g + 1;
      end
      @(posedge pclk);
      g = 1;
      while (match_a_irq !== 1'b1 && g < 2000) begin
        @(posedge pclk);
        g = g + 1;
      end
    end
  endtask
  initial begin
    void'($urandom(32'hf477));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TIECS_IDX_DIR);
    `CHK("dir_rst", 32'hff, rdv)
    rd(`TIECS_IDX_SW);
    `CHK("sw_rst", 32'h0, rdv)
    rd(`TIECS_IDX_TMC);
    `CHK("tmc_rst", 32'h0, rdv)
    rd(16'h0001);
    `CHK("unmapped", 1'b1, errv)
    // direction bits; upper nibble always reads one
    repeat (3) begin
      r8 = $urandom;
      wr(`TIECS_IDX_P3L, {24'h0, r8});
      wr(`TIECS_IDX_DIR, {24'h0, r8});
      rd(`TIECS_IDX_DIR);
      `CHK("dir", {24'h0, r8 | 8'hf0}, rdv)
      `CHK("oe_n", r8[3:0], port3_oe_n)
      `CHK("p3_out", r8[3:0], p3o)
    end
    // every interrupt 0 source choice
    for (s = 0; s < 4; s = s + 1) begin
      wr(`TIECS_IDX_SW, s | (s << 2));
      repeat (3) begin
        rx_r <= $urandom;
        ext_r <= $urandom;
        repeat (2) @(posedge pclk);
        `CHK("irq0", (s % 2) ? rx_r : ext_r, irq0_input)
      end
      `CHK("rx_en", s / 2, rx_en_w)
    end
    // interval timer, b set just below a
    wr(`TIECS_IDX_DIR, 32'hff);
    wr(`TIECS_IDX_PRM, 32'h0);
    m = 4 + $urandom % 20;
    wr(`TIECS_IDX_CRA, m);
    wr(`TIECS_IDX_CRB, m - 1);
    wr(`TIECS_IDX_TMC, 32'h0c);
    gap;
    `CHK("period", m + 1, g)
    nb = 0;
    gap;
    `CHK("period2", m + 1, g)
    `CHK("b_hits", 1, nb)
    rd(`TIECS_IDX_CNT);
    c1 = rdv;
    rd(`TIECS_IDX_CNT);
    `CHK("live_cnt", (c1 + 3) % (m + 1), rdv)
    wr(`TIECS_IDX_TMC, 32'h0d);
    rd(`TIECS_IDX_TMC);
    `CHK("ovf_set", 1'b1, rdv[0])
    wr(`TIECS_IDX_TMC, 32'h0);
    rd(`TIECS_IDX_TMC);
    `CHK("ovf_stop", 1'b0, rdv[0])
    rd(`TIECS_IDX_CNT);
    `CHK("stop_cnt", 32'h0, rdv)
    // event counting on port pin, then on the serial pin
    for (s = 0; s < 2; s = s + 1) begin
      wr(`TIECS_IDX_TMC, 32'h0);
      use_rx <= s;
      wr(`TIECS_IDX_SW, s ? 32'h2 : 32'h0);
      wr(`TIECS_IDX_DIR, 32'h08);
      m = 2 + $urandom % 4;
      wr(`TIECS_IDX_CRA, m);
      wr(`TIECS_IDX_PRM, 32'hb2);
      wr(`TIECS_IDX_TMC, 32'h0c);
      na = 0;
      send(m + 1, 4);
      `CHK("ev_early", 0, na)
      send(2, 1);
      `CHK("glitch", 0, na)
      send(1, 4);
      `CHK("ev_first", 1, na)
      send(m + 1, 4);
      `CHK("ev_next", 2, na)
      send(1, 4);
    end
    // clear and start on a rising pin edge
    wr(`TIECS_IDX_TMC, 32'h0);
    use_rx <= 1'b0;
    wr(`TIECS_IDX_SW, 32'h0);
    wr(`TIECS_IDX_PRM, 32'h10);
    wr(`TIECS_IDX_CRA, 32'hfff0);
    wr(`TIECS_IDX_CRB, 32'h5);
    nb = 0;
    wr(`TIECS_IDX_TMC, 32'h08);
    rd(`TIECS_IDX_CNT);
    c1 = rdv;
    rd(`TIECS_IDX_CNT);
    `CHK("runs_at_once", c1 + 3, rdv)
    send(1, 4);
    rd(`TIECS_IDX_CNT);
    `CHK("pin_clear", 1'b1, rdv < 32'h10)
    repeat (10) @(posedge pclk);
    `CHK("b_in_pin", 2, nb)
    wrap_up;
  end
endmodule
